/* File: pces_pkg.sv */
// Shared constants and types for the credit and error sideband block
package pces_pkg;
  localparam int HDR_W  = 8;
  localparam int DAT_W  = 12;
  localparam int NCAT   = 3;
  localparam int NPF    = 4;
  localparam int PF_W   = 2;
  localparam int VF_W   = 11;
  localparam int NERR   = 4;
  localparam int PEND_W = 8;
  localparam int HDR_CREDIT_BYTES = 20;
  localparam int DAT_CREDIT_BYTES = 16;
  localparam logic [1:0] SEL_POSTED    = 2'h0;
  localparam logic [1:0] SEL_NONPOSTED = 2'h1;
  localparam logic [1:0] SEL_CPL       = 2'h2;
  localparam int BIT_PH  = 5;
  localparam int BIT_PD  = 4;
  localparam int BIT_NPH = 3;
  localparam int BIT_NPD = 2;
  localparam int BIT_CH  = 1;
  localparam int BIT_CD  = 0;
  localparam int ERR_CTO_COR = 0;
  localparam int ERR_CTO_UNC = 1;
  localparam int ERR_CA      = 2;
  localparam int ERR_UC      = 3;
  localparam int SEV_CTO = 0;
  localparam int SEV_CA  = 1;
  localparam int SEV_UC  = 2;
  localparam logic [11:0] ADDR_LIM_P  = 12'h000;
  localparam logic [11:0] ADDR_LIM_NP = 12'h004;
  localparam logic [11:0] ADDR_LIM_C  = 12'h008;
  localparam logic [11:0] ADDR_INF    = 12'h00C;
  localparam logic [11:0] ADDR_SEV    = 12'h010;
  localparam logic [11:0] ADDR_PF_ERR = 12'h014;
  localparam logic [11:0] ADDR_VF_ERR = 12'h018;
  localparam logic [11:0] ADDR_MSG    = 12'h01C;
  localparam logic [11:0] ADDR_STAT   = 12'h020;
  localparam int LIM_HDR_LSB = 0;
  localparam int LIM_DAT_LSB = 8;
  localparam int VF_LAST_LSB = 16;
  localparam logic [HDR_W-1:0] LIM_HDR_RST = 8'h00;
  localparam logic [DAT_W-1:0] LIM_DAT_RST = 12'h000;
  localparam logic [5:0]       INF_RST     = 6'h00;
  localparam logic [2:0]       SEV_RST     = 3'h0;
  typedef enum logic [1:0] {MSG_COR, MSG_NONFATAL, MSG_FATAL} pces_msg_t;
endpackage

/* File: pces_crd_if.sv */
// Consumption requests and consumed counts between control and counters
`timescale 1ns/1ps
interface pces_crd_if;
  import pces_pkg::*;
  logic [NCAT-1:0]  hdr_use;
  logic [NCAT-1:0]  dat_use;
  logic [DAT_W-1:0] dat_amt;
  logic             clr;
  logic [HDR_W-1:0] hdr_cons [NCAT];
  logic [DAT_W-1:0] dat_cons [NCAT];
  modport ctl (output hdr_use, dat_use, dat_amt, clr, input hdr_cons, dat_cons);
  modport cnt (input hdr_use, dat_use, dat_amt, clr, output hdr_cons, dat_cons);
endinterface

/* File: pces_crd_cnt.sv */
// Per-category consumed credit counters
`timescale 1ns/1ps
module pces_crd_cnt
  import pces_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Counter side of the credit carrier
  pces_crd_if.cnt  crd
);
  for (genvar g = 0; g < NCAT; g++) begin : g_cat
    logic [HDR_W-1:0] hc_r;
    logic [DAT_W-1:0] dc_r;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        hc_r <= '0;
        dc_r <= '0;
      end else if (crd.clr) begin
        hc_r <= '0;
        dc_r <= '0;
      end else begin
        if (crd.hdr_use[g]) hc_r <= hc_r + 1'b1;
        if (crd.dat_use[g]) dc_r <= dc_r + crd.dat_amt;
      end
    end
    assign crd.hdr_cons[g] = hc_r;
    assign crd.dat_cons[g] = dc_r;
  end
endmodule

/* File: pces_err_log.sv */
// Error status logging and pending error message counts
`timescale 1ns/1ps
module pces_err_log
  import pces_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Error report
  input  wire logic [NERR-1:0]   err_in,
  input  wire logic [PF_W-1:0]   pf_id,
  input  wire logic              vf_flag,
  input  wire logic [VF_W-1:0]   vf_off,
  input  wire logic [2:0]        sev,
  // Software clears and message hand-off
  input  wire logic [NPF*NERR-1:0] pf_clr,
  input  wire logic [NERR-1:0]   vf_clr,
  input  wire logic              msg_take,
  output logic [NPF*NERR-1:0]    pf_sts,
  output logic [NERR-1:0]        vf_sts,
  output logic [VF_W-1:0]        vf_last,
  output logic                   pend_any,
  output pces_msg_t              pend_cls,
  output logic [PEND_W-1:0]      pend [3]
);
  logic [PEND_W-1:0] inc [3];
  logic [NPF*NERR-1:0] pf_set;
  pces_msg_t cls [NERR];

  // Fatal messages leave first
  assign pend_any = (pend[MSG_FATAL] != '0) | (pend[MSG_NONFATAL] != '0) | (pend[MSG_COR] != '0);
  assign pend_cls = (pend[MSG_FATAL] != '0) ? MSG_FATAL :
                    (pend[MSG_NONFATAL] != '0) ? MSG_NONFATAL : MSG_COR;
  assign cls[ERR_CTO_COR] = MSG_COR;
  assign cls[ERR_CTO_UNC] = sev[SEV_CTO] ? MSG_FATAL : MSG_NONFATAL;
  assign cls[ERR_CA]      = sev[SEV_CA] ? MSG_FATAL : MSG_COR;
  assign cls[ERR_UC]      = sev[SEV_UC] ? MSG_FATAL : MSG_COR;
  assign pf_set = vf_flag ? '0 : ({{(NPF-1)*NERR{1'b0}}, err_in} << (pf_id * NERR));

  // Several reports in one cycle each add a message of their own
  always_comb begin
    for (int k = 0; k < 3; k++) inc[k] = '0;
    for (int i = 0; i < NERR; i++) begin
      if (err_in[i]) inc[cls[i]] = inc[cls[i]] + 1'b1;
    end
  end

  for (genvar k = 0; k < 3; k++) begin : g_pend
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) pend[k] <= '0;
      else pend[k] <= pend[k] + inc[k] - PEND_W'(msg_take && (pend_cls == pces_msg_t'(k)));
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pf_sts  <= '0;
      vf_sts  <= '0;
      vf_last <= '0;
    end else begin
      pf_sts <= (pf_sts & ~pf_clr) | pf_set;
      vf_sts <= (vf_sts & ~vf_clr) | (vf_flag ? err_in : '0);
      if (vf_flag && (err_in != '0)) vf_last <= vf_off;
    end
  end
endmodule

/* File: pces_sideband.sv */
// Transmit credit reporting and completion error sideband, with APB registers
`timescale 1ns/1ps
module pces_sideband
  import pces_pkg::*;
#(
  parameter bit CONS_SEL_PORT_EN = 1'b1
)
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              NRST,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Link state
  input  wire logic              LINK_LAYER_UP,
  // Application transmit packet starts
  input  wire logic              TX_VALID,
  input  wire logic              TX_SOP,
  input  wire logic [1:0]        TX_CATEGORY,
  input  wire logic [DAT_W-1:0]  TX_DATA_CREDITS,
  output logic                   TX_STREAM_ACCEPT,
  // Credit reporting
  output logic [5:0]             IP_CONSUMED_CREDIT_PULSE,
  output logic [5:0]             INFINITE_CREDIT_FLAGS,
  input  wire logic [1:0]        CREDIT_CATEGORY_SELECT,
  input  wire logic              CONSUMED_VS_LIMIT_SELECT,
  output logic [HDR_W-1:0]       HEADER_CREDIT_VALUE,
  output logic [DAT_W-1:0]       DATA_CREDIT_VALUE,
  // Completion error reports
  input  wire logic [NERR-1:0]   COMPLETION_ERROR_REPORT,
  input  wire logic [PF_W-1:0]   ERROR_PHYS_FUNCTION_ID,
  input  wire logic              ERROR_VIRTUAL_FUNCTION_FLAG,
  input  wire logic [VF_W-1:0]   ERROR_VIRTUAL_FUNCTION_OFFSET,
  // Error messages toward the root complex
  output logic                   ERR_MSG_VALID,
  output logic [1:0]             ERR_MSG_CLASS
);

  // Category index to one-hot header or data position in the six-bit vectors
  function automatic logic [5:0] type_bit(input logic [1:0] cat, input logic data);
    logic [5:0] v;
    v = 6'h00;
    case (cat)
      SEL_POSTED:    v[data ? BIT_PD : BIT_PH] = 1'b1;
      SEL_NONPOSTED: v[data ? BIT_NPD : BIT_NPH] = 1'b1;
      SEL_CPL:       v[data ? BIT_CD : BIT_CH] = 1'b1;
      default:       v = 6'h00;
    endcase
    return v;
  endfunction

  function automatic logic [NCAT-1:0] cat_hot(input logic [1:0] cat);
    logic [NCAT-1:0] v;
    v = '0;
    case (cat)
      SEL_POSTED:    v[0] = 1'b1;
      SEL_NONPOSTED: v[1] = 1'b1;
      SEL_CPL:       v[2] = 1'b1;
      default:       v = '0;
    endcase
    return v;
  endfunction

  // Register state
  logic [HDR_W-1:0]       lim_hdr_r [NCAT];
  logic [DAT_W-1:0]       lim_dat_r [NCAT];
  logic [5:0]             inf_r;
  logic [2:0]             sev_r;
  logic [7:0]             sent_r;
  logic                   pready_r;
  logic                   pslverr_r;
  logic [31:0]            prdata_r;
  logic                   accept_r;
  logic [5:0]             cons_pulse_r;
  logic                   msg_valid_r;
  pces_msg_t              msg_class_r;
  logic [1:0]             sel_q_r;
  logic                   cons_q_r;
  logic [HDR_W-1:0]       hdr_val_r;
  logic [DAT_W-1:0]       dat_val_r;

  // Decode wires
  logic                   setup_rd;
  logic                   setup_any;
  logic                   wr_en;
  logic                   hit_lim;
  logic                   mapped;
  logic [1:0]             lim_idx;
  logic [31:0]            rd_mux;
  logic [5:0]             exh;
  logic                   app_take;
  logic                   msg_take;
  logic                   ph_ok;
  logic                   cons_sel_eff;
  logic [HDR_W-1:0]       hdr_pick;
  logic [DAT_W-1:0]       dat_pick;
  logic [NPF*NERR-1:0]    pf_clr;
  logic [NERR-1:0]        vf_clr;
  logic [NPF*NERR-1:0]    pf_sts;
  logic [NERR-1:0]        vf_sts;
  logic [VF_W-1:0]        vf_last;
  logic                   pend_any;
  pces_msg_t              pend_cls;
  logic [PEND_W-1:0]      pend [3];
  logic                   hit_inf;
  logic                   hit_sev;
  logic                   hit_pf;
  logic                   hit_vf;
  logic                   hit_msg;
  logic                   hit_stat;
  logic                   wr_lim;
  logic                   wr_inf;
  logic                   wr_sev;
  logic                   wr_pf;
  logic                   wr_vf;
  logic                   any_exh;

  // Next values
  logic                   pready_nxt;
  logic                   pslverr_nxt;
  logic [31:0]            prdata_nxt;
  logic                   accept_nxt;
  logic [5:0]             cons_pulse_nxt;
  logic [7:0]             sent_nxt;

  pces_crd_if crd ();

  pces_crd_cnt u_cnt (
    .clk  (CLK),
    .nrst (NRST),
    .crd  (crd.cnt)
  );

  pces_err_log u_err (
    .clk      (CLK),
    .nrst     (NRST),
    .err_in   (COMPLETION_ERROR_REPORT),
    .pf_id    (ERROR_PHYS_FUNCTION_ID),
    .vf_flag  (ERROR_VIRTUAL_FUNCTION_FLAG),
    .vf_off   (ERROR_VIRTUAL_FUNCTION_OFFSET),
    .sev      (sev_r),
    .pf_clr   (pf_clr),
    .vf_clr   (vf_clr),
    .msg_take (msg_take),
    .pf_sts   (pf_sts),
    .vf_sts   (vf_sts),
    .vf_last  (vf_last),
    .pend_any (pend_any),
    .pend_cls (pend_cls),
    .pend     (pend)
  );

  // APB decode; no wait states, so the answer comes in the first access cycle
  assign setup_any = PSEL & ~PENABLE;
  assign setup_rd  = setup_any & ~PWRITE;
  assign wr_en     = PSEL & PENABLE & PWRITE & pready_r;
  assign hit_lim   = (PADDR == ADDR_LIM_P) | (PADDR == ADDR_LIM_NP) | (PADDR == ADDR_LIM_C);
  assign hit_inf   = (PADDR == ADDR_INF);
  assign hit_sev   = (PADDR == ADDR_SEV);
  assign hit_pf    = (PADDR == ADDR_PF_ERR);
  assign hit_vf    = (PADDR == ADDR_VF_ERR);
  assign hit_msg   = (PADDR == ADDR_MSG);
  assign hit_stat  = (PADDR == ADDR_STAT);
  assign lim_idx   = PADDR[3:2];
  assign mapped    = hit_lim | hit_inf | hit_sev | hit_pf | hit_vf | hit_msg | hit_stat;

  // Write strobes act only at the edge that ends the access cycle
  assign wr_lim    = wr_en & hit_lim;
  assign wr_inf    = wr_en & hit_inf;
  assign wr_sev    = wr_en & hit_sev;
  assign wr_pf     = wr_en & hit_pf;
  assign wr_vf     = wr_en & hit_vf;
  assign pf_clr    = wr_pf ? PWDATA[NPF*NERR-1:0] : '0;
  assign vf_clr    = wr_vf ? PWDATA[NERR-1:0] : '0;

  // Answer registers load these at every edge; read data stays zero outside reads
  assign pready_nxt  = setup_any;
  assign pslverr_nxt = setup_any & ~mapped;
  assign prdata_nxt  = setup_rd ? rd_mux : 32'h0000_0000;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      ADDR_LIM_P, ADDR_LIM_NP, ADDR_LIM_C: begin
        rd_mux[LIM_HDR_LSB +: HDR_W] = lim_hdr_r[lim_idx];
        rd_mux[LIM_DAT_LSB +: DAT_W] = lim_dat_r[lim_idx];
      end
      ADDR_INF:    rd_mux[5:0] = inf_r;
      ADDR_SEV:    rd_mux[2:0] = sev_r;
      ADDR_PF_ERR: rd_mux[NPF*NERR-1:0] = pf_sts;
      ADDR_VF_ERR: begin
        rd_mux[NERR-1:0] = vf_sts;
        rd_mux[VF_LAST_LSB +: VF_W] = vf_last;
      end
      ADDR_MSG:    rd_mux = {sent_r, pend[MSG_FATAL], pend[MSG_NONFATAL], pend[MSG_COR]};
      ADDR_STAT:   rd_mux[7:0] = {LINK_LAYER_UP, accept_r, exh};
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // Limits stand in for what the link partner advertised, cumulative modulo width
  for (genvar k = 0; k < NCAT; k++) begin : g_lim
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        lim_hdr_r[k] <= LIM_HDR_RST;
        lim_dat_r[k] <= LIM_DAT_RST;
      end else if (wr_lim && lim_idx == 2'(k)) begin
        lim_hdr_r[k] <= PWDATA[LIM_HDR_LSB +: HDR_W];
        lim_dat_r[k] <= PWDATA[LIM_DAT_LSB +: DAT_W];
      end
    end
    // Exhausted when consumed has caught up with the limit, unless unlimited
    assign exh[5-2*k] = ~inf_r[5-2*k] & (lim_hdr_r[k] == crd.hdr_cons[k]);
    assign exh[4-2*k] = ~inf_r[4-2*k] & (lim_dat_r[k] == crd.dat_cons[k]);
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      inf_r <= INF_RST;
      sev_r <= SEV_RST;
    end else begin
      if (wr_inf) inf_r <= PWDATA[5:0];
      if (wr_sev) sev_r <= PWDATA[2:0];
    end
  end

  // Credit consumption: the application packet wins, a message waits a cycle
  assign app_take = TX_VALID & TX_SOP & accept_r;
  assign ph_ok    = inf_r[BIT_PH] | ~exh[BIT_PH];
  assign msg_take = pend_any & ~app_take & ph_ok & LINK_LAYER_UP;
  assign crd.clr  = ~LINK_LAYER_UP;
  assign crd.hdr_use = app_take ? cat_hot(TX_CATEGORY) :
                       (msg_take ? cat_hot(SEL_POSTED) : '0);
  assign crd.dat_use = (app_take && TX_DATA_CREDITS != '0) ? cat_hot(TX_CATEGORY) : '0;
  assign crd.dat_amt = TX_DATA_CREDITS;
  assign any_exh     = (exh != 6'h00);

  // Accept drops for one cycle after each packet start so the counters settle;
  // this costs a bubble per packet but never lets a stale accept overdraw.
  // An own message spends a posted header too, so it gets the same bubble
  assign accept_nxt = LINK_LAYER_UP & ~any_exh & ~app_take & ~msg_take;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      accept_r <= 1'b0;
    end else begin
      accept_r <= accept_nxt;
    end
  end

  // Error messages are posted without data: one posted header credit each
  assign cons_pulse_nxt = msg_take ? type_bit(SEL_POSTED, 1'b0) : 6'h00;
  assign sent_nxt       = sent_r + 8'h01;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cons_pulse_r <= 6'h00;
      msg_valid_r  <= 1'b0;
      msg_class_r  <= MSG_COR;
      sent_r       <= 8'h00;
    end else begin
      cons_pulse_r <= cons_pulse_nxt;
      msg_valid_r  <= msg_take;
      if (msg_take) begin
        msg_class_r <= pend_cls;
        sent_r      <= sent_nxt;
      end
    end
  end

  // Two-stage select path: sample the select, then register the chosen values
  assign cons_sel_eff = CONS_SEL_PORT_EN & CONSUMED_VS_LIMIT_SELECT;
  assign hdr_pick = (sel_q_r == 2'h3) ? '0 :
                    (cons_q_r ? crd.hdr_cons[sel_q_r] : lim_hdr_r[sel_q_r]);
  assign dat_pick = (sel_q_r == 2'h3) ? '0 :
                    (cons_q_r ? crd.dat_cons[sel_q_r] : lim_dat_r[sel_q_r]);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sel_q_r   <= SEL_POSTED;
      cons_q_r  <= 1'b0;
      hdr_val_r <= '0;
      dat_val_r <= '0;
    end else begin
      sel_q_r   <= CREDIT_CATEGORY_SELECT;
      cons_q_r  <= cons_sel_eff;
      hdr_val_r <= hdr_pick;
      dat_val_r <= dat_pick;
    end
  end

  assign PRDATA                   = prdata_r;
  assign PREADY                   = pready_r;
  assign PSLVERR                  = pslverr_r;
  assign TX_STREAM_ACCEPT         = accept_r;
  assign IP_CONSUMED_CREDIT_PULSE = cons_pulse_r;
  assign INFINITE_CREDIT_FLAGS    = inf_r;
  assign HEADER_CREDIT_VALUE      = hdr_val_r;
  assign DATA_CREDIT_VALUE        = dat_val_r;
  assign ERR_MSG_VALID            = msg_valid_r;
  assign ERR_MSG_CLASS            = msg_class_r;
endmodule

/* File: pces_app_model.sv */
// Application-side partner: packet starts, error reports, category select
`timescale 1ns/1ps
module pces_app_model (
  // Clock and core state
  input  wire logic   clk,
  input  wire logic   link_up,
  input  wire logic   accept,
  // Packet starts
  output logic        tx_valid,
  output logic        tx_sop,
  output logic [1:0]  tx_cat,
  output logic [11:0] tx_dat,
  // Error reports and credit select
  output logic [3:0]  err,
  output logic [1:0]  pf,
  output logic        vf_flag,
  output logic [10:0] vf_off,
  output logic [1:0]  sel
);
  initial begin
    tx_valid = 1'b0;
    tx_sop = 1'b0;
    tx_cat = 2'h0;
    tx_dat = 12'h000;
    err = 4'h0;
    pf = 2'h0;
    vf_flag = 1'b0;
    vf_off = 11'h000;
    sel = 2'h0;
  end
  // Released lines show the inverse or zero, except tx_cat, which holds, so stale values never pass for valid ones
  task automatic send(input logic [1:0] c, input logic [11:0] d);
    @(posedge clk);
    while (link_up !== 1'b1) @(posedge clk);
    tx_valid <= 1'b1;
    tx_sop <= 1'b1;
    tx_cat <= c;
    tx_dat <= d;
    @(posedge clk);
    while (accept !== 1'b1) @(posedge clk);
    tx_valid <= 1'b0;
    tx_sop <= 1'b0;
    tx_dat <= ~d;
  endtask
  task automatic set_sel(input logic [1:0] s);
    @(posedge clk);
    if (s != 2'h3) sel <= s;
  endtask
  task automatic report(input logic [3:0] b, input logic [1:0] p, input logic v,
                        input logic [10:0] o);
    @(posedge clk);
    err <= b;
    pf <= p;
    vf_flag <= v;
    vf_off <= o;
    @(posedge clk);
    err <= 4'h0;
    pf <= ~p;
    vf_flag <= ~v;
    vf_off <= ~o;
    if (b[2]) send(2'h2, 12'h001);
  endtask
endmodule

/* File: pces_sideband_sva.sv */
// Concurrent checks on the sideband ports
`timescale 1ns/1ps
module pces_sideband_sva
  import pces_pkg::*;
#(
  parameter bit CONS_SEL_PORT_EN = 1'b1
)
(
  // Clock and reset
  input wire logic            CLK,
  input wire logic            NRST,
  // APB slave
  input wire logic            PSEL,
  input wire logic            PENABLE,
  input wire logic            PWRITE,
  input wire logic [11:0]     PADDR,
  input wire logic [31:0]     PRDATA,
  input wire logic            PREADY,
  input wire logic            PSLVERR,
  // Credit side
  input wire logic            LINK_LAYER_UP,
  input wire logic            TX_VALID,
  input wire logic            TX_SOP,
  input wire logic            TX_STREAM_ACCEPT,
  input wire logic [5:0]      IP_CONSUMED_CREDIT_PULSE,
  input wire logic [5:0]      INFINITE_CREDIT_FLAGS,
  // Error side
  input wire logic [NERR-1:0] COMPLETION_ERROR_REPORT,
  input wire logic            ERR_MSG_VALID,
  input wire logic [1:0]      ERR_MSG_CLASS
);
  wire inf_wr = PSEL && PENABLE && PREADY && PWRITE && (PADDR == ADDR_INF);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence apb_setup_s; PSEL && !PENABLE; endsequence
  sequence tx_take_s; TX_VALID && TX_SOP && TX_STREAM_ACCEPT; endsequence
  // Message needs link and posted header credit, here made infinite
  sequence err_in_s;
    (COMPLETION_ERROR_REPORT != 4'h0) && LINK_LAYER_UP && INFINITE_CREDIT_FLAGS[5];
  endsequence
  apb_ready_a: assert property (apb_setup_s |=> PREADY)
    else $error("ready missing in first access cycle");
  apb_once_a: assert property (PREADY |=> !PREADY)
    else $error("ready held past one cycle");
  apb_idle_a: assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR)
    else $error("read data or error outside an answer");
  pulse_msg_a: assert property (IP_CONSUMED_CREDIT_PULSE == {ERR_MSG_VALID, 5'h00})
    else $error("consumed pulse not tied to an own message");
  take_drop_a: assert property (tx_take_s |=> !TX_STREAM_ACCEPT)
    else $error("accept not dropped after a packet start");
  link_drop_a: assert property (!LINK_LAYER_UP |=> !TX_STREAM_ACCEPT)
    else $error("accept high while link down");
  inf_write_a: assert property ($changed(INFINITE_CREDIT_FLAGS) |-> $past(inf_wr) || $past(inf_wr, 2))
    else $error("infinite flags changed without a write");
  msg_report_a: assert property (err_in_s |-> ##[1:24] ERR_MSG_VALID)
    else $error("error report produced no message");
  msg_link_a: assert property (ERR_MSG_VALID |-> $past(LINK_LAYER_UP))
    else $error("message sent while link down");
  msg_class_a: assert property (ERR_MSG_VALID |-> ERR_MSG_CLASS != 2'h3)
    else $error("message class undefined");
endmodule
bind pces_sideband pces_sideband_sva #(.CONS_SEL_PORT_EN(CONS_SEL_PORT_EN)) u_pces_sideband_sva (
  .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_LAYER_UP(LINK_LAYER_UP),
  .TX_VALID(TX_VALID), .TX_SOP(TX_SOP), .TX_STREAM_ACCEPT(TX_STREAM_ACCEPT),
  .IP_CONSUMED_CREDIT_PULSE(IP_CONSUMED_CREDIT_PULSE),
  .INFINITE_CREDIT_FLAGS(INFINITE_CREDIT_FLAGS),
  .COMPLETION_ERROR_REPORT(COMPLETION_ERROR_REPORT),
  .ERR_MSG_VALID(ERR_MSG_VALID), .ERR_MSG_CLASS(ERR_MSG_CLASS));

/* File: pces_sideband_bench.sv */
// Self-checking bench for the credit and error sideband
`timescale 1ns/1ps
module pces_sideband_bench;
  import pces_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, link, acc, tv, ts, cvl, mv;
  logic        vf;
  logic [11:0] paddr, td, dv, d;
  logic [31:0] pwdata, prdata;
  logic [1:0]  tc, sel, mc, pf, p;
  logic [5:0]  pulse, inf;
  logic [7:0]  hv;
  logic [3:0]  err;
  logic [10:0] vo, o;
  logic [2:0]  sev;
  logic [15:0] pfe;
  logic [7:0]  h [3];
  logic [11:0] dd [3];
  logic [32:0] apb_q [$];
  logic [1:0]  msg_q [$];
  int          failures, comparisons, seed;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  pces_sideband #(.CONS_SEL_PORT_EN(1'b1)) u_pces_sideband (
    .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LINK_LAYER_UP(link), .TX_VALID(tv), .TX_SOP(ts), .TX_CATEGORY(tc), .TX_DATA_CREDITS(td),
    .TX_STREAM_ACCEPT(acc), .IP_CONSUMED_CREDIT_PULSE(pulse), .INFINITE_CREDIT_FLAGS(inf),
    .CREDIT_CATEGORY_SELECT(sel), .CONSUMED_VS_LIMIT_SELECT(cvl), .HEADER_CREDIT_VALUE(hv),
    .DATA_CREDIT_VALUE(dv), .COMPLETION_ERROR_REPORT(err), .ERROR_PHYS_FUNCTION_ID(pf),
    .ERROR_VIRTUAL_FUNCTION_FLAG(vf), .ERROR_VIRTUAL_FUNCTION_OFFSET(vo),
    .ERR_MSG_VALID(mv), .ERR_MSG_CLASS(mc));
  pces_app_model u_pces_app_model (
    .clk(clk), .link_up(link), .accept(acc), .tx_valid(tv), .tx_sop(ts), .tx_cat(tc),
    .tx_dat(td), .err(err), .pf(pf), .vf_flag(vf), .vf_off(vo), .sel(sel));
  task automatic check(input logic [32:0] s, input logic [32:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [32:0] e);
    apb_q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [1:0] cls(input int i, input logic [2:0] s);
    case (i)
      ERR_CTO_COR: cls = MSG_COR;
      ERR_CTO_UNC: cls = s[SEV_CTO] ? MSG_FATAL : MSG_NONFATAL;
      ERR_CA:      cls = s[SEV_CA] ? MSG_FATAL : MSG_COR;
      default:     cls = s[SEV_UC] ? MSG_FATAL : MSG_COR;
    endcase
  endfunction
  // Oldest note is matched against each answer or message as it shows
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) check({pslverr, prdata}, apb_q.pop_front());
    if (mv === 1'b1) begin
      check(mc, (msg_q.size() > 0) ? msg_q.pop_front() : 2'h3);
      check(pulse, 6'h20);
    end
  end
  initial begin
    #500000;
    failures++;
    finish_test();
  end
  initial begin
    seed = 32'hFA352902;
    {nrst, psel, penable, pwrite, link, cvl} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, ADDR_LIM_P, 32'h0, 33'h0);
    apb(1'b0, ADDR_INF, 32'h0, 33'h0);
    apb(1'b0, ADDR_SEV, 32'h0, 33'h0);
    apb(1'b1, 12'h024, 32'hFFFFFFFF, 33'h100000000);
    apb(1'b0, 12'h024, 32'h0, 33'h100000000);
    link <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(acc, 1'b0);
    for (int c = 0; c < 3; c++) begin
      h[c] = 8'($random(seed)) | 8'h10;
      dd[c] = 12'($random(seed)) | 12'h800;
      apb(1'b1, 12'(c * 4), {12'h0, dd[c], h[c]}, 33'h0);
    end
    repeat (3) @(posedge clk);
    #1 check(acc, 1'b1);
    for (int k = 0; k < 3; k++) begin
      u_pces_app_model.set_sel(2'((k + 1) % 3));
      @(posedge clk);
      #1 check({dv, hv}, {dd[k], h[k]});
      @(posedge clk);
      #1 check({dv, hv}, {dd[(k + 1) % 3], h[(k + 1) % 3]});
    end
    @(posedge clk);
    cvl <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({dv, hv}, 20'h0);
    d = (12'($random(seed)) & 12'h007) | 12'h001;
    u_pces_app_model.send(SEL_POSTED, d);
    repeat (4) @(posedge clk);
    #1 check({pulse, dv, hv}, {6'h00, d, 8'h01});
    @(posedge clk);
    cvl <= 1'b0;
    apb(1'b1, ADDR_LIM_NP, {12'h0, dd[1], 8'h01}, 33'h0);
    u_pces_app_model.send(SEL_NONPOSTED, 12'h000);
    repeat (3) @(posedge clk);
    #1 check(acc, 1'b0);
    apb(1'b0, ADDR_STAT, 32'h0, 33'h88);
    apb(1'b1, ADDR_INF, 32'h28, 33'h0);
    repeat (3) @(posedge clk);
    #1 check({acc, inf}, {1'b1, 6'h28});
    sev = 3'($random(seed));
    apb(1'b1, ADDR_SEV, {29'h0, sev}, 33'h0);
    pfe = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      p = 2'($random(seed));
      msg_q.push_back(cls(i, sev));
      pfe[{p, 2'(i)}] = 1'b1;
      u_pces_app_model.report(4'(1 << i), p, 1'b0, 11'($random(seed)));
      repeat (6) @(posedge clk);
    end
    // Two requests from different functions, both fatal so order cannot matter
    apb(1'b1, ADDR_SEV, 32'h6, 33'h0);
    p = 2'($random(seed));
    msg_q.push_back(MSG_FATAL);
    msg_q.push_back(MSG_FATAL);
    pfe[{p, 2'h3}] = 1'b1;
    pfe[{~p, 2'h2}] = 1'b1;
    u_pces_app_model.report(4'h8, p, 1'b0, 11'h000);
    u_pces_app_model.report(4'h4, ~p, 1'b0, 11'h000);
    repeat (8) @(posedge clk);
    apb(1'b0, ADDR_PF_ERR, 32'h0, {17'h0, pfe});
    o = 11'($random(seed));
    msg_q.push_back(MSG_COR);
    u_pces_app_model.report(4'h1, p, 1'b1, o);
    repeat (6) @(posedge clk);
    apb(1'b0, ADDR_VF_ERR, 32'h0, {6'h0, o, 12'h0, 4'h1});
    // Let the monitor take the last answer off its queue first
    @(posedge clk);
    check(msg_q.size(), 33'h0);
    check(apb_q.size(), 33'h0);
    finish_test();
  end
endmodule
